// ---- hdl/blpm_top.sv ----
// Functional notes
// (R01) Low D-state write starts link L1/L2L3 transition
// (R02) Secondary clock runs only in D0/L0
// (R03) Reference clock may stop only in D3/L2L3
// (R04) Idle entry needs no pending, minimum idle
// (R05) Selection field limits L0s, L1 or both; with both selected the code only enters L0s autonomously, never L1
// (R06) Link capabilities report L0s and L1 latencies
// (R07) PM capability at 48h, express at 70h
// (R08) Sticky bits cleared by global or power-on only
// (R09) Second class survives hot reset only
// (R10) Remaining bits cleared by any reset
// (R11) Type 1 bridge header programming model
// (R12) Pending traffic wakes link, clocks restart first
`timescale 1ns/1ps
`default_nettype none
`include "blpm_cfg.svh"

module blpm_top
   import blpm_pkg::*;
#(
   parameter logic [2:0]  L0S_EXIT_LAT = 3'h1,
   parameter logic [2:0]  L1_EXIT_LAT  = 3'h2,
   parameter logic [15:0] PM_CAPS      = 16'h0003,
   parameter logic [15:0] EXP_CAPS     = 16'h0071,
   parameter logic [31:0] DEV_CAPS     = 32'h0000_0000,
   parameter logic [1:0]  BSE_VALUE    = 2'h0
) (
   input  wire logic          core_clk,
   input  wire logic          resetn,
   input  wire logic          global_reset_in_n,
   input  wire logic          fundamental_reset_in_n,
   input  wire logic          link_hot_reset,
   input  wire blpm_cfg_req_s cfg_req,
   output logic [31:0]        cfg_rdata,
   output logic               cfg_rvalid,
   input  wire logic          tx_pending,
   input  wire logic          tx_idle,
   input  wire logic          pme_event,
   output blpm_link_e         link_state,
   output logic               sec_clk_en,
   output logic               fwd_ok,
   output logic               link_reference_clock_in_stop_ok
);

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Reset classes, widest to narrowest
   wire clr_sticky = !global_reset_in_n;                      // R08
   wire clr_fund   = clr_sticky || !fundamental_reset_in_n;   // R09
   wire clr_hot    = clr_fund || link_hot_reset;              // R10

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : be_mask

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   wire [31:0] wmask    = be_mask(cfg_req.be);
   wire        wr_pmcsr = cfg_req.wr && cfg_req.addr == `BLPM_OFS_PM_CSR;
   wire        wr_devct = cfg_req.wr && cfg_req.addr == `BLPM_OFS_DEV_CTL;
   wire        wr_lnkct = cfg_req.wr && cfg_req.addr == `BLPM_OFS_LNK_CTL;

   blpm_dstate_e d_state;
   logic         pme_en;
   logic         pme_sts;
   logic [14:0]  dev_ctl;
   logic [1:0]   aspm_sel;
   logic [1:0]   lnk_cc;

   wire [1:0]  pm_wr_state = cfg_req.wdata[1:0];
   wire        pme_sts_w1c = wr_pmcsr && wmask[`BLPM_PMCSR_PME_STS] && cfg_req.wdata[`BLPM_PMCSR_PME_STS];

   // ----------------------------------------------------------------------
   // Sticky class
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pme_en  <= 1'b0;
         pme_sts <= 1'b0;
      end else if (clr_sticky) begin
         pme_en  <= 1'b0; // R08
         pme_sts <= 1'b0; // R08
      end else begin
         pme_en  <= (wr_pmcsr && wmask[`BLPM_PMCSR_PME_EN]) ? cfg_req.wdata[`BLPM_PMCSR_PME_EN] : pme_en;
         // A new event beats a clear in the same cycle
         pme_sts <= pme_event || (pme_sts && !pme_sts_w1c);
      end
   end

   // ----------------------------------------------------------------------
   // Fundamental class
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk_cc <= 2'h0;
      end else if (clr_fund) begin
         lnk_cc <= 2'h0; // R09
      end else if (wr_lnkct && cfg_req.be[0]) begin
         lnk_cc <= cfg_req.wdata[`BLPM_LCTL_CC_LSB +: 2];
      end
   end

   // ----------------------------------------------------------------------
   // Hot reset class
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         d_state  <= D0;
         dev_ctl  <= 15'h0000;
         aspm_sel <= 2'h0;
      end else if (clr_hot) begin
         d_state  <= D0; // R10
         dev_ctl  <= 15'h0000; // R10
         aspm_sel <= 2'h0; // R10
      end else begin
         d_state  <= (wr_pmcsr && cfg_req.be[0]) ? blpm_dstate_e'(pm_wr_state) : d_state; // R01
         dev_ctl  <= wr_devct ? ((cfg_req.wdata[14:0] & wmask[14:0]) | (dev_ctl & ~wmask[14:0])) : dev_ctl;
         aspm_sel <= (wr_lnkct && cfg_req.be[0]) ? cfg_req.wdata[1:0] : aspm_sel; // R05
      end
   end

   // ----------------------------------------------------------------------
   // Link power state machine
   // ----------------------------------------------------------------------
   blpm_lpm #(
      .IDLE_CYC (`BLPM_IDLE_CYC),
      .EXIT_CYC (`BLPM_EXIT_CYC)
   ) u_lpm (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .clr        (clr_hot),
      .d_state    (d_state),
      .aspm_sel   (aspm_sel),
      .tx_pending (tx_pending),
      .tx_idle    (tx_idle),
      .link_state (link_state),
      .sec_clk_en (sec_clk_en),
      .fwd_ok     (fwd_ok)
   );

   // The system keeps the reference clock up unless both D3 and L2/L3 hold
   assign link_reference_clock_in_stop_ok = (d_state == D3) && (link_state == ST_L23); // R03

   // ----------------------------------------------------------------------
   // Read words
   // ----------------------------------------------------------------------
   wire [31:0] rd_hdr   = {8'h00, `BLPM_HDR_TYPE_1, 16'h0000}; // R11
   wire [31:0] rd_pmcap = {PM_CAPS, `BLPM_PM_NEXT_PTR, `BLPM_PM_CAPABILITY_HEADER}; // R07
   wire [31:0] rd_pmcsr = {8'h00, BSE_VALUE, 6'h00, pme_sts, 6'h00, pme_en, 6'h00, d_state};
   wire [31:0] rd_expcp = {EXP_CAPS, `BLPM_EXP_NEXT_PTR, `BLPM_EXP_CAP_ID}; // R07
   wire [31:0] rd_devct = {10'h000, tx_pending, 6'h00, dev_ctl}; // Status bit 21: traffic pending
   wire [31:0] rd_lnkcp = {14'h0000, L1_EXIT_LAT, L0S_EXIT_LAT, 2'h3, 10'h000}; // R06
   wire [31:0] rd_lnkct = {13'h0000, link_state, 8'h00, lnk_cc, 4'h0, aspm_sel};

   // Unmapped offsets read as zero so software walking the space sees no capability
   wire [31:0] rd_word =
      (cfg_req.addr == `BLPM_OFS_HDR_TYPE) ? rd_hdr   :
      (cfg_req.addr == `BLPM_OFS_PM_CAP)   ? rd_pmcap :
      (cfg_req.addr == `BLPM_OFS_PM_CSR)   ? rd_pmcsr :
      (cfg_req.addr == `BLPM_OFS_EXP_CAP)  ? rd_expcp :
      (cfg_req.addr == `BLPM_OFS_DEV_CAP)  ? DEV_CAPS :
      (cfg_req.addr == `BLPM_OFS_DEV_CTL)  ? rd_devct :
      (cfg_req.addr == `BLPM_OFS_LNK_CAP)  ? rd_lnkcp :
      (cfg_req.addr == `BLPM_OFS_LNK_CTL)  ? rd_lnkct : `BLPM_RST_WORD;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata  <= `BLPM_RST_WORD;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rdata  <= cfg_req.rd ? rd_word : cfg_rdata;
         cfg_rvalid <= cfg_req.rd;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_read_pmcap;
      cfg_req.rd && cfg_req.addr == `BLPM_OFS_PM_CAP;
   endsequence

   a_pm_capability_header: assert property (@(posedge core_clk) disable iff (!rst_n) // R07
      s_read_pmcap |=> cfg_rvalid && cfg_rdata[7:0] == 8'h01)
      else $error("PM capability missing at 48h");
   a_exp_cap_id: assert property (@(posedge core_clk) disable iff (!rst_n) // R07
      (cfg_req.rd && cfg_req.addr == `BLPM_OFS_EXP_CAP) |=> cfg_rdata[7:0] == 8'h10)
      else $error("Express capability missing at 70h");
   a_link_lat: assert property (@(posedge core_clk) disable iff (!rst_n) // R06
      (cfg_req.rd && cfg_req.addr == `BLPM_OFS_LNK_CAP) |=> cfg_rdata[14:12] == L0S_EXIT_LAT
         && cfg_rdata[17:15] == L1_EXIT_LAT)
      else $error("Exit latencies not reported");
   a_sticky_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // R08
      (global_reset_in_n && !fundamental_reset_in_n && !cfg_req.wr) |=> $stable(pme_en))
      else $error("Sticky bit lost on fundamental reset");
   a_fund_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // R09
      (link_hot_reset && fundamental_reset_in_n && global_reset_in_n && !cfg_req.wr) |=> $stable(lnk_cc))
      else $error("Fundamental class cleared by hot reset");
   a_hot_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
      link_hot_reset |=> aspm_sel == 2'h0 && d_state == D0 && link_state == ST_L0)
      else $error("Hot reset did not clear control bits");
   a_link_reference_clock_in_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // R03
      link_reference_clock_in_stop_ok |-> d_state == D3)
      else $error("Reference clock released outside D3");
   a_d3_link: assert property (@(posedge core_clk) disable iff (!rst_n) // R01
      (wr_pmcsr && cfg_req.be[0] && pm_wr_state == 2'h3 && !clr_hot && link_state == ST_L0)
      |=> ##1 link_state == ST_L23)
      else $error("D3 write did not start L2/L3");

endmodule : blpm_top

`default_nettype wire

// ---- hdl/blpm_cfg.svh ----
`ifndef BLPM_CFG_SVH
`define BLPM_CFG_SVH

// ----------------------------------------------------------------------
// Configuration offsets
// ----------------------------------------------------------------------
`define BLPM_OFS_HDR_TYPE   12'h00C
`define BLPM_OFS_PM_CAP     12'h048
`define BLPM_OFS_PM_CSR     12'h04C
`define BLPM_OFS_EXP_CAP    12'h070
`define BLPM_OFS_DEV_CAP    12'h074
`define BLPM_OFS_DEV_CTL    12'h078
`define BLPM_OFS_LNK_CAP    12'h07C
`define BLPM_OFS_LNK_CTL    12'h080

// ----------------------------------------------------------------------
// Fixed field values
// ----------------------------------------------------------------------
`define BLPM_HDR_TYPE_1     8'h01
`define BLPM_PM_CAPABILITY_HEADER      8'h01
`define BLPM_PM_NEXT_PTR    8'h50
`define BLPM_EXP_CAP_ID     8'h10
`define BLPM_EXP_NEXT_PTR   8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BLPM_PMCSR_PME_EN   8
`define BLPM_PMCSR_PME_STS  15
`define BLPM_PM_BRIDGE_SUPPORT_EXT_LSB  22
`define BLPM_DEVSTS_TXPEND  21
`define BLPM_LCAP_ASPM_LSB  10
`define BLPM_LCAP_L0S_LSB   12
`define BLPM_LCAP_L1_LSB    15
`define BLPM_LCTL_CC_LSB    6
`define BLPM_LSTS_STATE_LSB 16

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define BLPM_RST_WORD       32'h0000_0000
`define BLPM_CLK_NS         50
`define BLPM_IDLE_MIN_NS    7000
`define BLPM_IDLE_CYC       ((`BLPM_IDLE_MIN_NS + `BLPM_CLK_NS - 1) / `BLPM_CLK_NS)
`define BLPM_EXIT_NS        1000
`define BLPM_EXIT_CYC       ((`BLPM_EXIT_NS + `BLPM_CLK_NS - 1) / `BLPM_CLK_NS)

`endif

// ---- hdl/blpm_pkg.sv ----
package blpm_pkg;

   typedef enum logic [1:0] {
      D0 = 2'h0,
      D1 = 2'h1,
      D2 = 2'h2,
      D3 = 2'h3
   } blpm_dstate_e;

   typedef enum logic [2:0] {
      ST_L0   = 3'h0,
      ST_L0S  = 3'h1,
      ST_L1   = 3'h2,
      ST_L23  = 3'h3,
      ST_EXIT = 3'h4
   } blpm_link_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } blpm_cfg_req_s;

endpackage : blpm_pkg

// ---- hdl/blpm_lpm.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "blpm_cfg.svh"

module blpm_lpm
   import blpm_pkg::*;
#(
   parameter int IDLE_CYC = `BLPM_IDLE_CYC,
   parameter int EXIT_CYC = `BLPM_EXIT_CYC
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic         clr,
   input  wire blpm_dstate_e d_state,
   input  wire logic [1:0]   aspm_sel,
   input  wire logic         tx_pending,
   input  wire logic         tx_idle,
   output blpm_link_e        link_state,
   output logic              sec_clk_en,
   output logic              fwd_ok
);

   blpm_link_e  next_link_state;
   logic [15:0] idle_cnt;
   logic [15:0] exit_cnt;
   logic        by_sw;
   wire         idle_now = !tx_pending && tx_idle;
   // A saturated count alone is stale once traffic appears, so entry also needs idle now
   wire         idle_ok  = idle_now && (idle_cnt >= 16'(IDLE_CYC)); // R04
   wire         low_d    = d_state != D0;
   wire         exit_done = exit_cnt >= 16'(EXIT_CYC - 1);
   wire         sw_target_l23 = d_state == D3;

   // ----------------------------------------------------------------------
   // Link power state machine
   // ----------------------------------------------------------------------
   always_comb begin
      next_link_state = link_state;
      unique case (link_state)
         ST_L0: begin
            if (low_d)
               next_link_state = sw_target_l23 ? ST_L23 : ST_L1; // R01
            else if (idle_ok && aspm_sel == 2'h2)
               next_link_state = ST_L1; // R04 R05
            else if (idle_ok && aspm_sel[0])
               next_link_state = ST_L0S; // R04 R05
         end
         ST_L0S: begin
            if (low_d)
               next_link_state = sw_target_l23 ? ST_L23 : ST_L1; // R01
            else if (tx_pending || !aspm_sel[0])
               next_link_state = ST_EXIT; // R12
         end
         ST_L1: begin
            if (sw_target_l23)
               next_link_state = ST_L23; // R01
            else if (!low_d && (by_sw || tx_pending || !aspm_sel[1]))
               next_link_state = ST_EXIT; // R12
         end
         ST_L23: begin
            if (!low_d)
               next_link_state = ST_EXIT;
         end
         ST_EXIT: begin
            if (exit_done)
               next_link_state = ST_L0;
         end
         default: next_link_state = ST_L0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_state <= ST_L0;
         idle_cnt   <= 16'h0000;
         exit_cnt   <= 16'h0000;
         by_sw      <= 1'b0;
         fwd_ok     <= 1'b0;
      end else if (clr) begin
         link_state <= ST_L0;
         idle_cnt   <= 16'h0000;
         exit_cnt   <= 16'h0000;
         by_sw      <= 1'b0;
         fwd_ok     <= 1'b0;
      end else begin
         link_state <= next_link_state;
         idle_cnt   <= (link_state == ST_L0 && idle_now && !idle_ok) ? idle_cnt + 16'h0001 :
                       (link_state == ST_L0 && idle_now) ? idle_cnt : 16'h0000; // R04
         exit_cnt   <= (link_state == ST_EXIT) ? exit_cnt + 16'h0001 : 16'h0000;
         by_sw      <= (link_state == ST_L0 || link_state == ST_L0S) ? low_d : by_sw;
         fwd_ok     <= sec_clk_en; // R12
      end
   end

   // Clock to the bridge function only in D0 with the link in L0
   assign sec_clk_en = (link_state == ST_L0) && !low_d; // R02

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_wake;
      link_state == ST_L1 && !low_d && tx_pending && !clr;
   endsequence

   a_dstate_l1: assert property (@(posedge core_clk) disable iff (!rst_n) // R01
      (link_state == ST_L0 && (d_state == D1 || d_state == D2) && !clr) |=> link_state == ST_L1)
      else $error("D1 or D2 did not bring L1");
   a_clock_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // R02
      sec_clk_en |-> (link_state == ST_L0 && d_state == D0))
      else $error("Secondary clock running outside D0 L0");
   a_idle_entry: assert property (@(posedge core_clk) disable iff (!rst_n) // R04
      (link_state == ST_L0 && !low_d && !clr ##1 (link_state == ST_L0S || link_state == ST_L1))
      |-> $past(idle_ok) && !$past(tx_pending))
      else $error("Idle entry without idle time");
   a_aspm_select: assert property (@(posedge core_clk) disable iff (!rst_n) // R05
      (link_state == ST_L0 && !low_d ##1 link_state == ST_L0S) |-> $past(aspm_sel[0]))
      else $error("L0s entered while not selected");
   a_wake_exit: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
      s_wake |=> link_state == ST_EXIT ##[1:200] (link_state == ST_L0 || clr))
      else $error("Pending traffic did not wake the link");
   a_fwd_clock: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
      fwd_ok |-> $past(sec_clk_en))
      else $error("Forwarding before clock restart");

endmodule : blpm_lpm

`default_nettype wire

// ---- dv/blpm_link_partner.sv ----
`timescale 1ns/1ps
`default_nettype none

module blpm_link_partner (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       traffic_req,
   input  wire logic [7:0] hold_cycles,
   input  wire logic       fwd_ok,
   input  wire logic       link_reference_clock_in_stop_ok,
   output var  logic       tx_pending,
   output var  logic       tx_idle,
   output var  logic       link_reference_clock_in
);
   // ------------------------------------------------------------------
   // Upstream traffic source
   // ------------------------------------------------------------------
   logic [7:0] hold_cnt;

   // Traffic stays pending until the bridge can forward it; a nonzero hold models a slow drain
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_pending <= 1'b0;
         tx_idle    <= 1'b1;
         hold_cnt   <= 8'h00;
      end else if (traffic_req) begin
         tx_pending <= 1'b1;
         tx_idle    <= 1'b0;
         hold_cnt   <= hold_cycles;
      end else if (tx_pending && fwd_ok) begin
         if (hold_cnt == 8'h00) begin
            tx_pending <= 1'b0;
            tx_idle    <= 1'b1;
         end else begin
            hold_cnt <= hold_cnt - 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // Reference clock
   // ------------------------------------------------------------------
   // Halted only while the bridge reports the deepest state
   initial begin
      link_reference_clock_in = 1'b0;
      forever #5 link_reference_clock_in = link_reference_clock_in_stop_ok ? 1'b0 : ~link_reference_clock_in;
   end
endmodule : blpm_link_partner

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import blpm_pkg::*;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} blpm_row_s;
   logic          core_clk               = 1'b0;
   logic          resetn                 = 1'b0;
   logic          global_reset_in_n      = 1'b1;
   logic          fundamental_reset_in_n = 1'b1;
   logic          link_hot_reset         = 1'b0;
   logic          pme_event              = 1'b0;
   logic          traffic_req            = 1'b0;
   logic [7:0]    hold_cycles            = 8'h00;
   blpm_cfg_req_s cfg_req                = '0;
   logic [31:0]   cfg_rdata;
   logic [31:0]   rd;
   logic          cfg_rvalid;
   logic          tx_pending;
   logic          tx_idle;
   logic          sec_clk_en;
   logic          fwd_ok;
   logic          link_reference_clock_in_stop_ok;
   blpm_link_e    link_state;
   int            n_mismatch             = 0;
   int            samples_checked        = 0;

   localparam blpm_row_s ROWS [10] = '{
      '{1'b0, 12'h048, 32'h0000_0000, 32'h0003_5001},
      '{1'b0, 12'h070, 32'h0000_0000, 32'h0071_0010},
      '{1'b0, 12'h07C, 32'h0000_0000, 32'h0001_1C00},
      '{1'b0, 12'h00C, 32'h0000_0000, 32'h0001_0000},
      '{1'b1, 12'h0F0, 32'hFFFF_FFFF, 32'h0000_0000},
      '{1'b1, 12'h048, 32'hFFFF_FFFF, 32'h0003_5001},
      '{1'b1, 12'h07C, 32'hFFFF_FFFF, 32'h0001_1C00},
      '{1'b1, 12'h078, 32'h0000_7FFF, 32'h0000_7FFF},
      '{1'b1, 12'h080, 32'h0000_00C0, 32'h0000_00C0},
      '{1'b1, 12'h04C, 32'h0000_0100, 32'h0000_0100}
   };

   always #25 core_clk = ~core_clk;

   blpm_top blpm_top_inst (
      .core_clk               (core_clk),
      .resetn                 (resetn),
      .global_reset_in_n      (global_reset_in_n),
      .fundamental_reset_in_n (fundamental_reset_in_n),
      .link_hot_reset         (link_hot_reset),
      .cfg_req                (cfg_req),
      .cfg_rdata              (cfg_rdata),
      .cfg_rvalid             (cfg_rvalid),
      .tx_pending             (tx_pending),
      .tx_idle                (tx_idle),
      .pme_event              (pme_event),
      .link_state             (link_state),
      .sec_clk_en             (sec_clk_en),
      .fwd_ok                 (fwd_ok),
      .link_reference_clock_in_stop_ok         (link_reference_clock_in_stop_ok)
   );

   blpm_link_partner blpm_link_partner_inst (
      .core_clk                (core_clk),
      .resetn                  (resetn),
      .traffic_req             (traffic_req),
      .hold_cycles             (hold_cycles),
      .fwd_ok                  (fwd_ok),
      .link_reference_clock_in_stop_ok          (link_reference_clock_in_stop_ok),
      .tx_pending              (tx_pending),
      .tx_idle                 (tx_idle),
      .link_reference_clock_in ()
   );

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic complete_run;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check32

   task automatic check_link(input string what, input blpm_link_e exp, input blpm_link_e got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check_link

   // Full-word access; the leading edge keeps back-to-back calls from driving twice in one step
   task automatic cfg_op(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk);
      #5;
      cfg_req = '{wr: w, rd: !w, addr: a, be: 4'hF, wdata: d};
      @(posedge core_clk);
      #5;
      cfg_req = '0;
      q = cfg_rdata;
      if (!w) check32("cfg_rvalid", 32'h0000_0001, {31'h0000_0000, cfg_rvalid});
   endtask : cfg_op

   task automatic wait_link(input blpm_link_e s, input int bound);
      for (int i = 0; i < bound && link_state !== s; i++) begin
         @(posedge core_clk);
         #1;
      end
      if (link_state !== s) begin
         n_mismatch++;
         $display("Error link_state wait expected %0d seen %0d", s, link_state);
         complete_run();
      end
   endtask : wait_link

   task automatic pulse_reset(input int k);
      @(posedge core_clk);
      #5;
      link_hot_reset = (k == 0);
      fundamental_reset_in_n = (k != 1);
      global_reset_in_n = (k != 2);
      @(posedge core_clk);
      #5;
      link_hot_reset = 1'b0;
      fundamental_reset_in_n = 1'b1;
      global_reset_in_n = 1'b1;
   endtask : pulse_reset

   task automatic send_traffic(input logic [7:0] h);
      @(posedge core_clk);
      #5;
      hold_cycles = h;
      traffic_req = 1'b1;
      @(posedge core_clk);
      #5;
      traffic_req = 1'b0;
   endtask : send_traffic

   task automatic check_wake;
      wait_link(ST_L0, 40);
      check32("clock restart", 32'h0000_0001, {31'h0000_0000, sec_clk_en});
      check32("forward held", 32'h0000_0000, {31'h0000_0000, fwd_ok});
      @(posedge core_clk);
      #1;
      check32("forward open", 32'h0000_0001, {31'h0000_0000, fwd_ok});
   endtask : check_wake

   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      #5;
      resetn = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      check32("reset clock", 32'h0000_0001, {31'h0000_0000, sec_clk_en});
      foreach (ROWS[i]) begin
         if (ROWS[i].w) cfg_op(1'b1, ROWS[i].a, ROWS[i].d, rd);
         cfg_op(1'b0, ROWS[i].a, 32'h0000_0000, rd);
         check32("table read", ROWS[i].e, rd);
      end
      // Status set by an event, then write-one-to-clear with the enable kept
      @(posedge core_clk);
      #5;
      pme_event = 1'b1;
      @(posedge core_clk);
      #5;
      pme_event = 1'b0;
      cfg_op(1'b0, 12'h04C, 32'h0000_0000, rd);
      check32("pme status", 32'h0000_8100, rd);
      cfg_op(1'b1, 12'h04C, 32'h0000_8100, rd);
      cfg_op(1'b0, 12'h04C, 32'h0000_0000, rd);
      check32("pme clear", 32'h0000_0100, rd);
      // Hot, then fundamental, then global reset against the three bit classes
      for (int k = 0; k < 3; k++) begin
         pulse_reset(k);
         cfg_op(1'b0, 12'h078, 32'h0000_0000, rd);
         check32("hot class", 32'h0000_0000, rd);
         cfg_op(1'b0, 12'h080, 32'h0000_0000, rd);
         check32("fundamental class", (k == 0) ? 32'h0000_00C0 : 32'h0000_0000, rd);
         cfg_op(1'b0, 12'h04C, 32'h0000_0000, rd);
         check32("sticky class", (k < 2) ? 32'h0000_0100 : 32'h0000_0000, rd);
      end
      // Software-directed D-states and the return to D0
      for (int d = 1; d < 4; d++) begin
         cfg_op(1'b1, 12'h04C, {30'h0000_0000, d[1:0]}, rd);
         repeat (2) @(posedge core_clk);
         #1;
         check_link("software entry", (d == 3) ? ST_L23 : ST_L1, link_state);
         check32("clock gated", 32'h0000_0000, {31'h0000_0000, sec_clk_en});
         check32("link_reference_clock_in stop", {31'h0000_0000, d == 3}, {31'h0000_0000, link_reference_clock_in_stop_ok});
         cfg_op(1'b1, 12'h04C, 32'h0000_0000, rd);
         check_wake();
      end
      // Autonomous entry per selection: 1, 2, 3, then 0 last so a saturated idle count cannot skew it
      for (int s = 1; s < 5; s++) begin
         send_traffic(8'h0A);
         cfg_op(1'b1, 12'h080, {30'h0000_0000, 2'(s % 4)}, rd);
         repeat (100) @(posedge core_clk);
         #1;
         check_link("early entry", ST_L0, link_state);
         if (s == 4) begin
            repeat (100) @(posedge core_clk);
            #1;
            check_link("entry disabled", ST_L0, link_state);
         end else begin
            wait_link((s == 2) ? ST_L1 : ST_L0S, 80);
            send_traffic(8'(s));
            check_wake();
         end
      end
      // Power-on reset in mid-run while the link sits in L0s
      cfg_op(1'b1, 12'h080, 32'h0000_0001, rd);
      wait_link(ST_L0S, 200);
      #4;
      resetn = 1'b0;
      #1;
      check_link("reset link", ST_L0, link_state);
      check32("reset clock async", 32'h0000_0001, {31'h0000_0000, sec_clk_en});
      @(posedge core_clk);
      #5;
      resetn = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      check32("reset forward", 32'h0000_0001, {31'h0000_0000, fwd_ok});
      cfg_op(1'b0, 12'h080, 32'h0000_0000, rd);
      check32("power-on clear", 32'h0000_0000, rd);
      complete_run();
   end
endmodule : tb_top

`default_nettype wire
